// ### pkg/fwo_defines.svh
// Purpose: Named constants for the FSK word output back end.
// Assumes: System clock of 25 MHz; nominal master oscillator of 3.579545 MHz.
// Notes: Timing counts are in master oscillator ticks produced by a phase accumulator.
// Notes on behaviour
// - Mode input high selects buffered, externally clocked readout.
// - Sample data bits; drop start and stop bits.
// - Eighth bit loads shift register, word ready low.
// - Each shift clock rise presents next received bit.
// - First shift clock pulse releases word ready.
// - Unread word ready releases after half bit.
// - After eight shifts, further shift clocks ignored.
// - Sleep stops oscillator and ignores line input.
// - Sleep: flags hi-Z direct, driven high buffered.
// - Sleep in direct mode: data, shift clock high.
// - Releasing sleep resumes normal reception.
// - Carrier asserted only after digital energy qualification.
// - Carrier released after 10 ms without activity.
// - Without carrier, timing recovery ignores demodulator.
// - Direct, no carrier: data high, no pulses.
// - Buffered, no carrier: no load, no word ready.
// - All timing derived from 3.579545 MHz master clock.
// - Direct mode: eight shift clocks at bit centres.
// - Direct mode: word ready pulse per 10-bit frame.
// - Timing built for nominal 1200 baud.
`ifndef FWO_DEFINES_SVH
`define FWO_DEFINES_SVH

// Clock rates in hertz.
`define FWO_CLK_HZ       32'h017D_7840
`define FWO_OSC_HZ       32'h0036_9E99
`define FWO_BAUD         32'h0000_04B0
// Phase accumulator width and increment that rebuild the master tick.
`define FWO_NCO_BITS     5'h18
`define FWO_NCO_INC      24'(((64'(`FWO_OSC_HZ)) << `FWO_NCO_BITS) / 64'(`FWO_CLK_HZ))
// Bit timing in master ticks: a full bit rounded, a half bit rounded down.
`define FWO_BIT_TICKS    12'((`FWO_OSC_HZ + (`FWO_BAUD >> 1)) / `FWO_BAUD)
`define FWO_HALF_TICKS   12'(`FWO_OSC_HZ / (`FWO_BAUD << 1))
// Carrier release hold time in milliseconds and its tick count.
`define FWO_HOLD_MS      32'h0000_000A
`define FWO_MS_PER_S     32'h0000_03E8
`define FWO_HOLD_TICKS   16'((`FWO_OSC_HZ * `FWO_HOLD_MS) / `FWO_MS_PER_S)
// Continuous energy needed before the carrier flag is raised.
`define FWO_QUAL_TICKS   16'h0DFB
// Number of data bits in a character.
`define FWO_DATA_BITS    4'h8
// Register map, byte addresses.
`define FWO_ADDR_CTRL    4'h0
`define FWO_ADDR_STATUS  4'h4
// Control and status field positions.
`define FWO_CTRL_SLEEP   0
`define FWO_ST_CARRIER   0
`define FWO_ST_WREADY    1
`define FWO_ST_MODE      2
`define FWO_ST_ASLEEP    3
`define FWO_ST_BYTE_LO   8
`define FWO_ST_BYTE_HI   15

`endif

// ### pkg/fwo_pkg.sv
// Purpose: Types shared by the FSK word output back end.
// Assumes: Used together with fwo_defines.svh.
// Notes: Receiver states are Gray coded along the usual path.
package fwo_pkg;

  // Character receiver states.
  typedef enum logic [1:0] {
    FWO_RX_IDLE  = 2'h0,
    FWO_RX_START = 2'h1,
    FWO_RX_DATA  = 2'h3,
    FWO_RX_STOP  = 2'h2
  } fwo_rx_state_t;

endpackage

// ### core/fwo_sync.sv
// Purpose: Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs are levels that stay stable for several clocks.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module fwo_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;  // First stage, may go metastable.

  // Both stages reset to zero; callers invert active-low pins before entry.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// ### core/fwo_core.sv
// Purpose: FSK receiver back end: carrier qualification, framing and 3-wire output.
// Assumes: Demodulated data and band energy arrive as asynchronous levels.
// Notes: An Avalon-MM slave gives software a sleep control and a status view.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`include "fwo_defines.svh"
`timescale 1ns/1ps
module fwo_core
  import fwo_pkg::*;
#(
  parameter logic [11:0] BIT_TICKS  = `FWO_BIT_TICKS,
  parameter logic [11:0] HALF_TICKS = `FWO_HALF_TICKS,
  parameter logic [15:0] HOLD_TICKS = `FWO_HOLD_TICKS,
  parameter logic [15:0] QUAL_TICKS = `FWO_QUAL_TICKS
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        demod_in,
  input  wire logic        band_energy_in,
  input  wire logic        mode_in,
  input  wire logic        sleep_request_in,
  input  wire logic        shift_clock_in,
  output logic             shift_clock_out,
  output logic             shift_clock_oe_n_out,
  output logic             data_out,
  output logic             word_ready_n_out,
  output logic             word_ready_n_oe_n_out,
  output logic             carrier_present_n_out,
  output logic             carrier_present_n_oe_n_out,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);

  // Synchronised pin levels.
  logic [4:0]    sync_w;          // All five asynchronous inputs after two flops.
  logic          demod_s;         // Demodulated line data.
  logic          energy_s;        // Band energy present.
  logic          mode_s;          // High selects buffered readout.
  logic          sleep_pin_s;     // Sleep request pin.
  logic          sclk_s;          // Shift clock from the controller.
  logic          sclk_prev_ff;    // Previous shift clock for edge detection.
  logic          demod_prev_ff;   // Previous data level for start detection.
  logic          sclk_rise;       // One-cycle pulse on a shift clock rising edge.
  // Control state.
  logic          soft_sleep_ff;   // Software sleep request.
  logic          asleep;          // Combined sleep request.
  logic [23:0]   nco_ff;          // Phase accumulator for the master tick.
  logic          tick_ff;         // One master oscillator tick.
  logic [24:0]   nxt_nco;         // Accumulator sum with carry.
  logic          carrier_ff;      // Carrier qualified.
  logic [15:0]   qual_cnt_ff;     // Ticks of continuous energy.
  logic [15:0]   quiet_cnt_ff;    // Ticks without energy.
  fwo_rx_state_t rx_state_ff;     // Character receiver state.
  logic [11:0]   rx_timer_ff;     // Ticks within the current bit.
  logic [3:0]    bit_idx_ff;      // Data bits taken so far.
  logic [7:0]    rx_byte_ff;      // Assembly register, LSB arrives first.
  logic          rx_en;           // Receiver allowed to run.
  logic          rx_step;         // Timer reaches its target this tick.
  logic          bit_sample;      // Centre of a data bit.
  logic          byte_done;       // Eighth data bit sampled.
  logic          frame_end;       // Stop bit centre reached.
  logic [11:0]   rx_target;       // Current timer target.
  logic [7:0]    out_sr_ff;       // Buffered output shift register.
  logic [3:0]    shifted_ff;      // Bits already shifted out.
  logic          wr_low_ff;       // Word ready asserted.
  logic [11:0]   wr_cnt_ff;       // Ticks word ready has been low.
  logic          shift_clock_hi_ff;      // Direct-mode shift clock high phase.
  logic [11:0]   shift_clock_cnt_ff;     // Ticks of the shift clock high phase.
  logic          data_ff;         // Registered data pin level.
  logic          ack_ff;          // Bus answer cycle.
  logic [31:0]   rdata_ff;        // Captured read data.

  // Two flops on every pin before any logic looks at it.
  fwo_sync #(.WIDTH(5)) u_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in ({demod_in, band_energy_in, mode_in, sleep_request_in, shift_clock_in}),
    .sync_out (sync_w)
  );
  assign {demod_s, energy_s, mode_s, sleep_pin_s, sclk_s} = sync_w;

  assign asleep    = sleep_pin_s | soft_sleep_ff;
  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign rx_en     = carrier_ff & ~asleep;

  // Edge history for the shift clock and the data line.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_prev_ff  <= 1'b0;
      demod_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff  <= sclk_s;
      demod_prev_ff <= demod_s;
    end
  end

  // Master tick: the accumulator rebuilds the oscillator rate from clk_in.
  // It stops while asleep, and every timer below is held cleared while asleep.
  assign nxt_nco = {1'b0, nco_ff} + {1'b0, `FWO_NCO_INC};
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nco_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (asleep) begin
      nco_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      nco_ff  <= nxt_nco[23:0];
      tick_ff <= nxt_nco[24];
    end
  end

  // Carrier qualification: energy must persist before the flag rises, and
  // only sleep or a full hold time of silence drops it, riding out brief dropouts.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carrier_ff   <= 1'b0;
      qual_cnt_ff  <= '0;
      quiet_cnt_ff <= '0;
    end else if (asleep) begin
      carrier_ff   <= 1'b0;
      qual_cnt_ff  <= '0;
      quiet_cnt_ff <= '0;
    end else if (!carrier_ff) begin
      quiet_cnt_ff <= '0;
      if (!energy_s) begin
        qual_cnt_ff <= '0;
      end else if (tick_ff) begin
        if (qual_cnt_ff == QUAL_TICKS - 16'h0001) begin
          carrier_ff <= 1'b1;
        end
        qual_cnt_ff <= qual_cnt_ff + 16'h0001;
      end
    end else begin
      qual_cnt_ff <= '0;
      if (energy_s) begin
        quiet_cnt_ff <= '0;
      end else if (tick_ff) begin
        if (quiet_cnt_ff == HOLD_TICKS - 16'h0001) begin
          carrier_ff <= 1'b0;
        end
        quiet_cnt_ff <= quiet_cnt_ff + 16'h0001;
      end
    end
  end

  // Timer target: half a bit to the start bit centre, then whole bits.
  assign rx_target  = (rx_state_ff == FWO_RX_START) ? HALF_TICKS : BIT_TICKS;
  // Gated by the receiver enable so a carrier drop can never finish a byte.
  assign rx_step    = rx_en && tick_ff && (rx_timer_ff == rx_target - 12'h001);
  assign bit_sample = rx_step && (rx_state_ff == FWO_RX_DATA);
  assign byte_done  = bit_sample && (bit_idx_ff == `FWO_DATA_BITS - 4'h1);
  assign frame_end  = rx_step && (rx_state_ff == FWO_RX_STOP);

  // Character receiver; start and stop bits are only timed, never kept.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state_ff <= FWO_RX_IDLE;
      rx_timer_ff <= '0;
      bit_idx_ff  <= '0;
      rx_byte_ff  <= '0;
    end else if (!rx_en) begin
      rx_state_ff <= FWO_RX_IDLE;
      rx_timer_ff <= '0;
      bit_idx_ff  <= '0;
    end else begin
      if (rx_step || rx_state_ff == FWO_RX_IDLE) begin
        rx_timer_ff <= '0;
      end else if (tick_ff) begin
        rx_timer_ff <= rx_timer_ff + 12'h001;
      end
      case (rx_state_ff)
        FWO_RX_IDLE: begin
          // A falling edge marks a possible start bit.
          if (demod_prev_ff && !demod_s) begin
            rx_state_ff <= FWO_RX_START;
          end
        end
        FWO_RX_START: begin
          // A start bit that is high again at its centre was a glitch.
          if (rx_step) begin
            rx_state_ff <= demod_s ? FWO_RX_IDLE : FWO_RX_DATA;
            bit_idx_ff  <= '0;
          end
        end
        FWO_RX_DATA: begin
          if (bit_sample) begin
            rx_byte_ff <= {demod_s, rx_byte_ff[7:1]};
            bit_idx_ff <= bit_idx_ff + 4'h1;
            if (byte_done) begin
              rx_state_ff <= FWO_RX_STOP;
            end
          end
        end
        FWO_RX_STOP: begin
          if (frame_end) begin
            rx_state_ff <= FWO_RX_IDLE;
          end
        end
        default: begin
          rx_state_ff <= FWO_RX_IDLE;
        end
      endcase
    end
  end

  // Buffered output register. A load restarts the shift count; a rising
  // shift clock moves the next bit, oldest first, onto the data pin.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_sr_ff  <= '0;
      shifted_ff <= `FWO_DATA_BITS;
    end else if (mode_s && byte_done) begin
      out_sr_ff  <= {demod_s, rx_byte_ff[7:1]};
      shifted_ff <= '0;
    end else if (mode_s && sclk_rise && shifted_ff != `FWO_DATA_BITS) begin
      out_sr_ff  <= {1'b0, out_sr_ff[7:1]};
      shifted_ff <= shifted_ff + 4'h1;
    end
  end

  // Word ready: low for half a bit, or until the first read in buffered mode.
  // A new load in the same cycle as a read wins and restarts the low phase.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_low_ff <= 1'b0;
      wr_cnt_ff <= '0;
    end else if (asleep || (!mode_s && !carrier_ff)) begin
      wr_low_ff <= 1'b0;
      wr_cnt_ff <= '0;
    end else if ((mode_s && byte_done) || (!mode_s && frame_end)) begin
      wr_low_ff <= 1'b1;
      wr_cnt_ff <= '0;
    end else if (wr_low_ff) begin
      if (mode_s && sclk_rise) begin
        wr_low_ff <= 1'b0;
      end else if (tick_ff) begin
        if (wr_cnt_ff == HALF_TICKS - 12'h001) begin
          wr_low_ff <= 1'b0;
        end
        wr_cnt_ff <= wr_cnt_ff + 12'h001;
      end
    end
  end

  // Direct-mode shift clock: rises at each data bit centre, high for half a bit.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_clock_hi_ff  <= 1'b0;
      shift_clock_cnt_ff <= '0;
    end else if (mode_s || asleep || !carrier_ff) begin
      shift_clock_hi_ff  <= 1'b0;
      shift_clock_cnt_ff <= '0;
    end else if (bit_sample) begin
      shift_clock_hi_ff  <= 1'b1;
      shift_clock_cnt_ff <= '0;
    end else if (shift_clock_hi_ff && tick_ff) begin
      if (shift_clock_cnt_ff == HALF_TICKS - 12'h001) begin
        shift_clock_hi_ff <= 1'b0;
      end
      shift_clock_cnt_ff <= shift_clock_cnt_ff + 12'h001;
    end
  end

  // Data pin register. Direct mode passes line data only under carrier.
  // In buffered mode the pin takes the shift register output bit at each accepted shift clock rise.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_ff <= 1'b1;
    end else if (!mode_s) begin
      data_ff <= asleep || !carrier_ff || demod_s;
    end else if (mode_s && sclk_rise && shifted_ff != `FWO_DATA_BITS) begin
      data_ff <= out_sr_ff[0];
    end
  end

  // Pin drivers. Flags are open drain in direct mode and released while
  // asleep there; in buffered mode they are push-pull and park high.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_clock_out            <= 1'b1;
      shift_clock_oe_n_out       <= 1'b1;
      word_ready_n_out           <= 1'b1;
      word_ready_n_oe_n_out      <= 1'b1;
      carrier_present_n_out      <= 1'b1;
      carrier_present_n_oe_n_out <= 1'b1;
    end else begin
      shift_clock_out      <= asleep || shift_clock_hi_ff;
      shift_clock_oe_n_out <= mode_s;
      word_ready_n_out     <= !wr_low_ff;
      carrier_present_n_out <= !carrier_ff;
      if (mode_s) begin
        word_ready_n_oe_n_out      <= 1'b0;
        carrier_present_n_oe_n_out <= 1'b0;
      end else begin
        word_ready_n_oe_n_out      <= asleep || !wr_low_ff;
        carrier_present_n_oe_n_out <= asleep || !carrier_ff;
      end
    end
  end
  assign data_out = data_ff;

  // Avalon-MM slave: every access is answered one cycle after it is seen.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_ff;
  assign avs_readdata_out    = rdata_ff;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= (avs_read_in || avs_write_in) && !ack_ff;
      if (avs_read_in && !ack_ff) begin
        rdata_ff <= '0;
        case (avs_address_in)
          `FWO_ADDR_CTRL: begin
            rdata_ff[`FWO_CTRL_SLEEP] <= soft_sleep_ff;
          end
          `FWO_ADDR_STATUS: begin
            rdata_ff[`FWO_ST_CARRIER] <= carrier_ff;
            rdata_ff[`FWO_ST_WREADY]  <= wr_low_ff;
            rdata_ff[`FWO_ST_MODE]    <= mode_s;
            rdata_ff[`FWO_ST_ASLEEP]  <= asleep;
            rdata_ff[`FWO_ST_BYTE_HI:`FWO_ST_BYTE_LO] <= out_sr_ff;
          end
          default: begin
            rdata_ff <= '0;
          end
        endcase
      end
    end
  end

  // Software sleep bit, written at the answer edge only.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_sleep_ff <= 1'b0;
    end else if (avs_write_in && ack_ff && avs_address_in == `FWO_ADDR_CTRL) begin
      soft_sleep_ff <= avs_writedata_in[`FWO_CTRL_SLEEP];
    end
  end

  // Checks on the observable behaviour.
  sequence buffered_load_s;
    mode_s && byte_done && !asleep;
  endsequence
  sequence direct_sleep_s;
    (asleep && !mode_s) [*2];
  endsequence

  word_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mode_s && wr_low_ff && sclk_rise && !byte_done |=> !wr_low_ff)
    else $error("Word ready not cleared by first read.");
  word_timeout_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_low_ff |-> wr_cnt_ff < HALF_TICKS)
    else $error("Word ready held past half a bit.");
  byte_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    buffered_load_s |=> wr_low_ff && out_sr_ff == rx_byte_ff ##1 !word_ready_n_out)
    else $error("Byte not loaded with word ready.");
  shift_ignore_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mode_s && shifted_ff == `FWO_DATA_BITS && !byte_done |=> $stable(data_ff))
    else $error("Shift clock honoured after last bit.");
  shift_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mode_s && $past(mode_s) && sclk_rise && shifted_ff < `FWO_DATA_BITS && !byte_done
    |=> data_ff == $past(out_sr_ff[0]) && shifted_ff == $past(shifted_ff) + 4'h1)
    else $error("Shifted bit out of order.");
  sleep_pins_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    direct_sleep_s |=> word_ready_n_oe_n_out && carrier_present_n_oe_n_out
    && shift_clock_out && data_out)
    else $error("Direct sleep pins wrong.");
  carrier_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !carrier_ff |=> rx_state_ff == FWO_RX_IDLE)
    else $error("Receiver ran without carrier.");
  direct_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !mode_s && !carrier_ff |=> data_ff && !wr_low_ff && !shift_clock_hi_ff)
    else $error("Direct mode active without carrier.");

endmodule

// ### sim/fwo_mcu_model.sv
// Purpose: Controller model that reads each buffered byte with a shift clock.
// Assumes: Shift clock of 320 ns (4 clk high, 4 clk low); it idles low between bytes.
// Notes: Data is sampled one clk into each low phase, once the core has shifted.
`timescale 1ns/1ps
module fwo_mcu_model (
  input  wire logic       clk_in,
  input  wire logic       word_ready_n_in,
  input  wire logic       data_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] extra_in,
  output logic            shift_clock_out,
  output logic [7:0]      byte_out,
  output logic            first_wr_out,
  output logic            last_out,
  output logic [7:0]      reads_out
);
  // Waits for word ready, then gives eight pulses plus any extra ones.
  initial begin
    shift_clock_out = 1'h0;
    byte_out = 8'h00;
    first_wr_out = 1'h0;
    last_out = 1'h0;
    reads_out = 8'h00;
    forever begin
      @(posedge clk_in);
      if (enable_in && word_ready_n_in === 1'h0) begin
        for (int i = 0; i < 8 + extra_in; i++) begin
          shift_clock_out <= 1'h1;
          repeat (4) @(posedge clk_in);
          shift_clock_out <= 1'h0;
          @(posedge clk_in);
          // Bits arrive least significant first, so bit i lands at position i.
          if (i < 8) byte_out[i] = data_in;
          if (i == 0) first_wr_out = word_ready_n_in;
          last_out = data_in;
          repeat (3) @(posedge clk_in);
        end
        reads_out <= reads_out + 8'h01;
      end
    end
  end
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the FSK word output back end.
// Assumes: Ticks cut to bit 20, half 10, hold 200, qualify 20; about 7 clk per tick.
// Notes: Flag pins are pulled high when released; a bit lasts 140 clk here.
`timescale 1ns/1ps
module testbench;
  localparam int BITC = 140; // Clocks per line bit.
  logic        clk_in = 1'h0;
  logic        rstn_in = 1'h0;
  logic        demod_in = 1'h1;
  logic        band_energy_in = 1'h0;
  logic        mode_in = 1'h1;
  logic        sleep_request_in = 1'h0;
  logic        mcu_en = 1'h1;
  logic [3:0]  extra = 4'h0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'h0;
  logic        avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic        shift_clock_out, shift_clock_oe_n_out, data_out, avs_waitrequest_out;
  logic        word_ready_n_out, word_ready_n_oe_n_out, mcu_sc, first_wr, last_bit;
  logic        carrier_present_n_out, carrier_present_n_oe_n_out;
  logic        sc_q = 1'h0, wr_q = 1'h1;
  logic [7:0]  rbyte, reads, r0, f0, l0, dbyte = 8'h00, rises = 8'h00, falls = 8'h00;
  logic [7:0]  lows = 8'h00;
  int          error_cnt = 0, comparisons = 0;
  // Each row is the byte sent on the line beside the byte the controller must read.
  logic [15:0] rows [4] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h3C3C};
  wire         wr_pin = word_ready_n_oe_n_out ? 1'h1 : word_ready_n_out;
  wire         cp_pin = carrier_present_n_oe_n_out ? 1'h1 : carrier_present_n_out;
  wire         sc_pin = shift_clock_oe_n_out ? mcu_sc : shift_clock_out;

  // Free running 25 MHz clock.
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  fwo_core #(
    .BIT_TICKS  (12'h014),
    .HALF_TICKS (12'h00A),
    .HOLD_TICKS (16'h00C8),
    .QUAL_TICKS (16'h0014)
  ) i_fwo_core (
    .clk_in, .rstn_in, .demod_in, .band_energy_in, .mode_in, .sleep_request_in,
    .shift_clock_in (sc_pin),
    .shift_clock_out, .shift_clock_oe_n_out, .data_out, .word_ready_n_out,
    .word_ready_n_oe_n_out, .carrier_present_n_out, .carrier_present_n_oe_n_out,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out
  );

  fwo_mcu_model i_fwo_mcu_model (
    .clk_in, .word_ready_n_in (wr_pin), .data_in (data_out), .enable_in (mcu_en),
    .extra_in (extra), .shift_clock_out (mcu_sc), .byte_out (rbyte),
    .first_wr_out (first_wr), .last_out (last_bit), .reads_out (reads)
  );

  // Counts pin events; tests compare deltas, so stray counts elsewhere do no harm.
  always @(posedge clk_in) begin
    sc_q <= shift_clock_out;
    wr_q <= wr_pin;
    if (shift_clock_out && !sc_q) begin
      dbyte <= {data_out, dbyte[7:1]};
      rises <= rises + 8'h01;
    end
    if (!wr_pin && wr_q) falls <= falls + 8'h01;
    if (!data_out) lows <= lows + 8'h01;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One Avalon transfer, held until waitrequest is sampled low at a rising edge.
  // The leading edge keeps a second call off the time step of the last release.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'h0 && t < 50) begin
      @(posedge clk_in);
      t++;
    end
    if (t >= 50) error_cnt++;
    q = avs_readdata_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  // Sends one 10-bit frame, start bit first and data least significant first.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      demod_in <= f[i];
      clks(BITC - 1);
    end
  endtask

  task automatic read_byte(input logic [7:0] b);
    int t;
    t = 0;
    r0 = reads;
    send(b);
    while (reads === r0 && t < 4000) begin
      @(posedge clk_in);
      t++;
    end
    if (t >= 4000) error_cnt++;
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    clks(10);
    chk("reset_pins", {word_ready_n_oe_n_out, carrier_present_n_oe_n_out, data_out}, 3'h7);
    rstn_in <= 1'h1;
    clks(4);
    bus(1'h0, 4'h4, 32'h0);
    chk("mode_bit", q[2], 1'h1);
    bus(1'h0, 4'h8, 32'h0);
    chk("unmapped", q, 32'h0);
    band_energy_in <= 1'h1;
    clks(100);
    chk("cp_early", cp_pin, 1'h1);
    clks(100);
    chk("cp_on", cp_pin, 1'h0);
    for (int i = 0; i < 4; i++) begin
      read_byte(rows[i][15:8]);
      chk("byte", rbyte, rows[i][7:0]);
      chk("first_clear", first_wr, 1'h1);
    end
    // Nobody reads this word, so word ready must drop back by itself.
    mcu_en <= 1'h0;
    fork
      send(8'h81);
      begin
        wait (wr_pin === 1'h0);
        clks(30);
        chk("wr_hold", wr_pin, 1'h0);
        clks(70);
        chk("wr_auto", wr_pin, 1'h1);
        bus(1'h0, 4'h4, 32'h0);
        chk("st_load", {q[15:8], q[1]}, 9'h102);
      end
    join
    mcu_en <= 1'h1;
    extra <= 4'h4;
    read_byte(8'h96);
    chk("byte_extra", rbyte, 8'h96);
    chk("hold_last", last_bit, 1'h1);
    extra <= 4'h0;
    band_energy_in <= 1'h0;
    clks(700);
    band_energy_in <= 1'h1;
    clks(10);
    chk("cp_dropout", cp_pin, 1'h0);
    band_energy_in <= 1'h0;
    clks(1300);
    chk("cp_hold", cp_pin, 1'h0);
    clks(200);
    chk("cp_off", cp_pin, 1'h1);
    f0 = falls;
    send(8'h55);
    clks(BITC);
    chk("no_load", falls, f0);
    sleep_request_in <= 1'h1;
    band_energy_in <= 1'h1;
    clks(300);
    chk("flags_sleep_b", {word_ready_n_oe_n_out, word_ready_n_out,
      carrier_present_n_oe_n_out, carrier_present_n_out}, 4'h5);
    bus(1'h0, 4'h4, 32'h0);
    chk("asleep", q[3], 1'h1);
    sleep_request_in <= 1'h0;
    clks(300);
    read_byte(8'hC3);
    chk("byte_wake", rbyte, 8'hC3);
    mode_in <= 1'h0;
    bus(1'h1, 4'h0, 32'h1);
    clks(5);
    chk("pins_sleep_d", {word_ready_n_oe_n_out, carrier_present_n_oe_n_out, data_out,
      shift_clock_out, shift_clock_oe_n_out}, 5'h1E);
    bus(1'h0, 4'h0, 32'h0);
    chk("ctrl_rb", q[0], 1'h1);
    bus(1'h1, 4'h0, 32'h0);
    clks(300);
    r0 = rises;
    f0 = falls;
    send(8'h5A);
    chk("shift_clock_cnt", rises - r0, 8'h08);
    chk("shift_clock_data", dbyte, 8'h5A);
    chk("dr_pulse", falls - f0, 8'h01);
    band_energy_in <= 1'h0;
    clks(1500);
    r0 = rises;
    f0 = falls;
    l0 = lows;
    send(8'h00);
    chk("direct_idle", {rises - r0, falls - f0, lows - l0}, 24'h0);
    wrap_up();
  end

  // Cuts a hang short well beyond the expected run of about 19000 clk.
  initial begin
    clks(80000);
    error_cnt++;
    wrap_up();
  end
endmodule
